// >>> verilog/sp_pkg.sv
// Constants and state types of the serial port.
// Assumes one oscillator clock and timer overflow pulses on that clock.
package sp_pkg;
	// --------------------------------------------------------------
	// Register map
	// --------------------------------------------------------------
	localparam logic [7:0] SP_CTRL_ADDR = 8'h98;
	localparam logic [7:0] SP_BUF_ADDR = 8'h9c;
	localparam logic [7:0] SP_CFG_ADDR = 8'ha0;
	localparam int SP_MODE_HI = 7;
	localparam int SP_MODE_LO = 6;
	localparam int SP_MP = 5;
	localparam int SP_REN = 4;
	localparam int SP_TB8 = 3;
	localparam int SP_RB8 = 2;
	localparam int SP_TI = 1;
	localparam int SP_RI = 0;
	localparam int SP_CFG_TX_SRC = 0;
	localparam int SP_CFG_RX_SRC = 1;
	localparam int SP_CFG_FAST = 2;
	localparam int SP_CFG_TX_BUSY = 4;
	localparam int SP_CFG_RX_BUSY = 5;
	localparam logic [7:0] SP_CTRL_RST = 8'h00;
	localparam logic [2:0] SP_CFG_RST = 3'h0;
	// --------------------------------------------------------------
	// Timing in oscillator cycles and sample ticks
	// --------------------------------------------------------------
	localparam logic [3:0] SP_M0_DIV = 4'hc;
	localparam logic [3:0] SP_M0_LAST = SP_M0_DIV - 4'h1;
	localparam logic [3:0] SP_M0_HALF = SP_M0_DIV >> 1;
	localparam logic [3:0] SP_SMP_A = 4'h7;
	localparam logic [3:0] SP_SMP_B = 4'h8;
	localparam logic [3:0] SP_SMP_C = 4'h9;
	localparam logic [3:0] SP_BIT_LAST = 4'hf;
	localparam logic [3:0] SP_LAST_M0 = 4'h7;
	localparam logic [3:0] SP_LAST_U8 = 4'h9;
	localparam logic [3:0] SP_LAST_U9 = 4'ha;
	// --------------------------------------------------------------
	// Types
	// --------------------------------------------------------------
	typedef enum logic [1:0] {SP_SHIFT, SP_UART8, SP_UART9F, SP_UART9V} sp_mode_t;
	typedef enum logic [1:0] {SP_TX_IDLE, SP_TX_WAIT, SP_TX_SEND} sp_tx_t;
	typedef enum logic [1:0] {SP_RX_IDLE, SP_RX_WAIT, SP_RX_M0, SP_RX_ASYNC} sp_rx_t;
	typedef struct packed {
		logic wreq;
		logic [31:0] rdata;
		logic [7:0] ctl;
		logic [2:0] cfg;
		logic [7:0] rbuf;
		logic rxd_meta;
		logic rxd_sync;
		logic [1:0] osc_cnt;
		logic [3:0] m0_cnt;
		sp_tx_t tx_state;
		logic [3:0] tx_div;
		logic [3:0] tx_bit;
		logic [10:0] tx_shift;
		logic tx_line;
		sp_rx_t rx_state;
		logic [3:0] rx_div;
		logic [3:0] rx_bit;
		logic [7:0] rx_shift;
		logic rx_ninth;
		logic [1:0] rx_smp;
		logic rx_prev;
		logic txd;
		logic rxd_out;
		logic rxd_oe;
		logic irq;
	} sp_state_t;
endpackage

// >>> verilog/sp_serial_port.sv
// Full duplex serial port with four modes behind an Avalon-MM slave.
// Assumes timer overflow pulses are one clk_in cycle wide on clk_in.
`timescale 1ns/10ps
`default_nettype none
module sp_serial_port
	import sp_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [7:0] address_in,
	input wire logic read_in,
	input wire logic write_in,
	input wire logic [31:0] writedata_in,
	output logic [31:0] readdata_out,
	output logic waitrequest_out,
	input wire logic t1_ovf_in,
	input wire logic t2_ovf_in,
	input wire logic rxd_in,
	output logic rxd_out,
	output logic rxd_oe_out,
	output logic txd_out,
	output logic irq_out
);
	sp_state_t s;
	sp_state_t n;
	sp_mode_t mode;
	logic req;
	logic acc;
	logic m2_tick;
	logic tx_tick;
	logic rx_tick;
	logic m0_end;
	logic tx_end;
	logic vote;
	logic accept;
	logic rx_fin;
	logic [3:0] tx_last;
	logic [3:0] rx_last;

	// --------------------------------------------------------------
	// Next state
	// --------------------------------------------------------------
	always_comb
	begin
		n = s;
		vote = 1'b0;
		accept = 1'b0;
		rx_fin = 1'b0;
		mode = sp_mode_t'(s.ctl[SP_MODE_HI:SP_MODE_LO]);
		n.rxd_meta = rxd_in;
		n.rxd_sync = s.rxd_meta;
		n.osc_cnt = s.osc_cnt + 2'h1;
		n.m0_cnt = (s.m0_cnt == SP_M0_LAST) ? 4'h0 : s.m0_cnt + 4'h1;
		m0_end = s.m0_cnt == SP_M0_LAST;
		m2_tick = s.cfg[SP_CFG_FAST] ? s.osc_cnt[0] : &s.osc_cnt;
		// Per direction timer baud source, except SP_UART9F where both directions use m2_tick
		if (mode == SP_UART9F)
		begin
			tx_tick = m2_tick;
			rx_tick = m2_tick;
		end
		else
		begin
			tx_tick = s.cfg[SP_CFG_TX_SRC] ? t2_ovf_in : t1_ovf_in;
			rx_tick = s.cfg[SP_CFG_RX_SRC] ? t2_ovf_in : t1_ovf_in;
		end
		if (mode == SP_SHIFT)
		begin
			tx_last = SP_LAST_M0;
			rx_last = SP_LAST_M0;
		end
		else if (mode == SP_UART8)
		begin
			tx_last = SP_LAST_U8;
			rx_last = SP_LAST_U8;
		end
		else
		begin
			tx_last = SP_LAST_U9;
			rx_last = SP_LAST_U9;
		end

		// --------------------------------------------------------------
		// Bus slave: one wait cycle, then the answer
		// --------------------------------------------------------------
		req = read_in || write_in;
		n.wreq = !(req && s.wreq);
		acc = write_in && !s.wreq;
		if (req && s.wreq)
		begin
			unique case (address_in)
				SP_CTRL_ADDR: n.rdata = {24'h0, s.ctl};
				SP_BUF_ADDR: n.rdata = {24'h0, s.rbuf};
				SP_CFG_ADDR: n.rdata = {26'h0, s.rx_state != SP_RX_IDLE,
					s.tx_state != SP_TX_IDLE, 1'b0, s.cfg};
				default: n.rdata = 32'h0;
			endcase
		end
		if (acc && address_in == SP_CTRL_ADDR)
			n.ctl = writedata_in[7:0];
		if (acc && address_in == SP_CFG_ADDR)
			n.cfg = writedata_in[2:0];

		// --------------------------------------------------------------
		// Transmitter
		// --------------------------------------------------------------
		if (tx_tick)
			n.tx_div = s.tx_div + 4'h1;
		tx_end = (mode == SP_SHIFT) ? m0_end : (tx_tick && s.tx_div == SP_BIT_LAST);
		unique case (s.tx_state)
			SP_TX_IDLE:
				n.tx_line = 1'b1;
			SP_TX_WAIT:
				if (tx_end)
				begin
					n.tx_state = SP_TX_SEND;
					n.tx_bit = 4'h0;
					n.tx_line = s.tx_shift[0];
				end
			SP_TX_SEND:
				if (tx_end)
				begin
					if (s.tx_bit == tx_last)
					begin
						n.tx_state = SP_TX_IDLE;
						n.tx_line = 1'b1;
						n.ctl[SP_TI] = 1'b1;
					end
					else
					begin
						n.tx_shift = {1'b1, s.tx_shift[10:1]};
						n.tx_bit = s.tx_bit + 4'h1;
						n.tx_line = s.tx_shift[1];
					end
				end
			default:
				n.tx_state = SP_TX_IDLE;
		endcase
		if (acc && address_in == SP_BUF_ADDR)
		begin
			n.tx_state = SP_TX_WAIT;
			if (mode == SP_SHIFT)
				n.tx_shift = {3'b111, writedata_in[7:0]};
			else if (mode == SP_UART8)
				n.tx_shift = {2'b11, writedata_in[7:0], 1'b0};
			else
				n.tx_shift = {1'b1, s.ctl[SP_TB8], writedata_in[7:0], 1'b0};
		end

		// --------------------------------------------------------------
		// Receiver
		// --------------------------------------------------------------
		unique case (s.rx_state)
			SP_RX_IDLE:
				if (mode == SP_SHIFT)
				begin
					if (s.ctl[SP_REN] && !s.ctl[SP_RI] && s.tx_state == SP_TX_IDLE)
						n.rx_state = SP_RX_WAIT;
				end
				else if (rx_tick)
				begin
					n.rx_prev = s.rxd_sync;
					if (s.rx_prev && !s.rxd_sync && s.ctl[SP_REN])
					begin
						n.rx_state = SP_RX_ASYNC;
						n.rx_div = 4'h0;
						n.rx_bit = 4'h0;
					end
				end
			SP_RX_WAIT:
				if (m0_end)
				begin
					n.rx_state = SP_RX_M0;
					n.rx_bit = 4'h0;
				end
			SP_RX_M0:
			begin
				if (s.m0_cnt == SP_M0_HALF)
					n.rx_shift = {s.rxd_sync, s.rx_shift[7:1]};
				if (m0_end)
				begin
					if (s.rx_bit == rx_last)
					begin
						n.rx_state = SP_RX_IDLE;
						n.rbuf = s.rx_shift;
						n.ctl[SP_RI] = 1'b1;
					end
					else
						n.rx_bit = s.rx_bit + 4'h1;
				end
			end
			SP_RX_ASYNC:
				if (rx_tick)
				begin
					n.rx_div = s.rx_div + 4'h1;
					if (s.rx_div == SP_SMP_A)
						n.rx_smp[0] = s.rxd_sync;
					if (s.rx_div == SP_SMP_B)
						n.rx_smp[1] = s.rxd_sync;
					if (s.rx_div == SP_SMP_C)
					begin
						vote = (s.rx_smp[0] & s.rx_smp[1]) | (s.rxd_sync
							& (s.rx_smp[0] | s.rx_smp[1]));
						if (s.rx_bit == 4'h0 && vote)
						begin
							n.rx_state = SP_RX_IDLE;
							n.rx_prev = 1'b1;
						end
						else if (s.rx_bit == rx_last)
						begin
							rx_fin = 1'b1;
							if (mode == SP_UART8)
								accept = !s.ctl[SP_MP] || vote;
							else
								accept = !s.ctl[SP_MP] || s.rx_ninth;
							if (accept)
							begin
								n.rbuf = s.rx_shift;
								n.ctl[SP_RB8] = (mode == SP_UART8) ? vote : s.rx_ninth;
								n.ctl[SP_RI] = 1'b1;
							end
							n.rx_state = SP_RX_IDLE;
							n.rx_prev = vote;
						end
						else if (s.rx_bit == SP_LAST_U8)
							n.rx_ninth = vote;
						else if (s.rx_bit != 4'h0)
							n.rx_shift = {vote, s.rx_shift[7:1]};
					end
					if (s.rx_div == SP_BIT_LAST)
						n.rx_bit = s.rx_bit + 4'h1;
				end
			default:
				n.rx_state = SP_RX_IDLE;
		endcase

		// --------------------------------------------------------------
		// Pins and request
		// --------------------------------------------------------------
		if (mode == SP_SHIFT)
		begin
			n.txd = !(n.tx_state == SP_TX_SEND || n.rx_state == SP_RX_M0)
				|| n.m0_cnt >= SP_M0_HALF;
			n.rxd_oe = n.tx_state == SP_TX_SEND;
		end
		else
		begin
			n.txd = n.tx_line;
			n.rxd_oe = 1'b0;
		end
		n.rxd_out = n.tx_line;
		n.irq = n.ctl[SP_TI] | n.ctl[SP_RI];
	end

	// --------------------------------------------------------------
	// State register
	// --------------------------------------------------------------
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			s <= '0;
			s.wreq <= 1'b1;
			s.ctl <= SP_CTRL_RST;
			s.cfg <= SP_CFG_RST;
			s.tx_line <= 1'b1;
			s.rx_prev <= 1'b1;
			s.txd <= 1'b1;
			s.rxd_out <= 1'b1;
		end
		else
			s <= n;
	end

	assign readdata_out = s.rdata;
	assign waitrequest_out = s.wreq;
	assign rxd_out = s.rxd_out;
	assign rxd_oe_out = s.rxd_oe;
	assign txd_out = s.txd;
	assign irq_out = s.irq;

	// --------------------------------------------------------------
	// Checks
	// --------------------------------------------------------------
	property p_buf_write;
		@(posedge clk_in) disable iff (rst_in)
		(write_in && !s.wreq && address_in == SP_BUF_ADDR) |=> s.tx_state == SP_TX_WAIT;
	endproperty
	a_buf_write: assert property (p_buf_write) else $error("buffer write did not start send");

	property p_ti_set;
		@(posedge clk_in) disable iff (rst_in)
		(s.tx_state == SP_TX_SEND && tx_end && s.tx_bit == tx_last) |=> s.ctl[SP_TI] && irq_out;
	endproperty
	a_ti_set: assert property (p_ti_set) else $error("transmit done not set");

	property p_mp_filter;
		@(posedge clk_in) disable iff (rst_in)
		(rx_fin && mode != SP_UART8 && s.ctl[SP_MP] && !s.rx_ninth && !s.ctl[SP_RI]
			&& !(write_in && !s.wreq)) |=> !s.ctl[SP_RI];
	endproperty
	a_mp_filter: assert property (p_mp_filter) else $error("filtered frame set receive done");

	property p_stop_filter;
		@(posedge clk_in) disable iff (rst_in)
		(rx_fin && mode == SP_UART8 && s.ctl[SP_MP] && !vote && !s.ctl[SP_RI]
			&& !(write_in && !s.wreq)) |=> !s.ctl[SP_RI];
	endproperty
	a_stop_filter: assert property (p_stop_filter) else $error("bad stop set receive done");

	property p_oe_mode0;
		@(posedge clk_in) disable iff (rst_in)
		rxd_oe_out |-> s.ctl[SP_MODE_HI:SP_MODE_LO] == 2'b00;
	endproperty
	a_oe_mode0: assert property (p_oe_mode0) else $error("rxd driven outside shift mode");

	property p_start_low;
		@(posedge clk_in) disable iff (rst_in)
		(mode != SP_SHIFT && s.tx_state == SP_TX_SEND && s.tx_bit == 4'h0) |-> !txd_out;
	endproperty
	a_start_low: assert property (p_start_low) else $error("start bit not low");

	property p_ren_off;
		@(posedge clk_in) disable iff (rst_in)
		(s.rx_state == SP_RX_IDLE && !s.ctl[SP_REN]) |=> s.rx_state == SP_RX_IDLE;
	endproperty
	a_ren_off: assert property (p_ren_off) else $error("reception while disabled");

	property p_false_start;
		@(posedge clk_in) disable iff (rst_in)
		(s.rx_state == SP_RX_ASYNC && rx_tick && s.rx_div == SP_SMP_C && s.rx_bit == 4'h0
			&& s.rx_smp == 2'b11) |=> s.rx_state == SP_RX_IDLE;
	endproperty
	a_false_start: assert property (p_false_start) else $error("false start accepted");

	property p_bus_answer;
		@(posedge clk_in) disable iff (rst_in)
		(read_in && waitrequest_out) |-> ##1 !waitrequest_out ##1 waitrequest_out;
	endproperty
	a_bus_answer: assert property (p_bus_answer) else $error("bus answer not one cycle");

	property p_m0_clock;
		@(posedge clk_in) disable iff (rst_in)
		(mode == SP_SHIFT && s.tx_state == SP_TX_SEND && s.m0_cnt == 4'h0
			&& !(write_in && !s.wreq)) |-> !txd_out ##6 txd_out;
	endproperty
	a_m0_clock: assert property (p_m0_clock) else $error("shift clock not oscillator/12");
endmodule
`default_nettype wire

// >>> tb/sp_remote_model.sv
// Remote serial device: async sender and receiver, shift-mode peripheral.
// Assumes the bench resolves the rxd wire from this line and the port's enable.
`timescale 1ns/10ps
`default_nettype none
module sp_remote_model (
	input wire logic clk_in,
	input wire logic txd_in,
	input wire logic rxd_in,
	output var logic line_out
);
	// Pull-up level while not driving
	initial line_out = 1'b1;
	// Leave level lv, then return to it, bounded
	task automatic wait_txd(input logic lv, inout logic ok);
		int n;
		n = 0;
		for (int p = 0; p < 2; p++)
			while (ok && ((txd_in === lv) ^ (p == 1)))
			begin
				@(posedge clk_in);
				n++;
				ok = n < 4000;
			end
	endtask
	task automatic send(input logic [10:0] f, input int n, input int bc);
		for (int i = 0; i < n; i++)
		begin
			line_out <= f[i];
			repeat (bc) @(posedge clk_in);
		end
		line_out <= 1'b1;
	endtask
	task automatic recv(input int n, input int bc, output logic [10:0] v, inout logic ok);
		v = 11'h7ff;
		wait_txd(1'b0, ok);
		repeat (bc / 2) @(posedge clk_in);
		for (int i = 0; i < n; i++)
		begin
			v[i] = txd_in;
			repeat (bc) @(posedge clk_in);
		end
	endtask
	task automatic shift_cap(output logic [7:0] v, inout logic ok);
		for (int i = 0; i < 8; i++)
		begin
			wait_txd(1'b1, ok);
			v[i] = rxd_in;
		end
	endtask
	// Data changes on falling shift clock, stable at rising
	task automatic shift_in(input logic [7:0] v, inout logic ok);
		line_out <= v[0];
		for (int i = 1; i < 9; i++)
		begin
			wait_txd(1'b1, ok);
			if (i < 8)
			begin
				wait_txd(1'b0, ok);
				line_out <= v[i];
			end
		end
		repeat (6) @(posedge clk_in);
		line_out <= 1'b1;
	endtask
endmodule
`default_nettype wire

// >>> tb/sp_serial_port_bench.sv
// Self-checking bench for the serial port: bus tasks plus remote model.
// Assumes timer ticks are made here, one clk_in cycle wide.
`timescale 1ns/10ps
`default_nettype none
module sp_serial_port_bench
	import sp_pkg::*;
();
	localparam int T1P = 8;
	localparam int T2P = 6;
	logic clk_in = 1'b0;
	logic rst_in, read_in, write_in, t1_ovf_in, t2_ovf_in, rxd_in, model_line;
	logic [7:0] address_in;
	logic [31:0] writedata_in, readdata_out;
	logic waitrequest_out, rxd_out, rxd_oe_out, txd_out, irq_out;
	int c1 = 0, c2 = 0, error_cnt = 0, n_tests = 0;
	assign rxd_in = rxd_oe_out ? rxd_out : model_line;
	always #25 clk_in = ~clk_in;
	always @(posedge clk_in)
	begin
		c1 <= (c1 == T1P - 1) ? 0 : c1 + 1;
		c2 <= (c2 == T2P - 1) ? 0 : c2 + 1;
		t1_ovf_in <= (c1 == T1P - 1);
		t2_ovf_in <= (c2 == T2P - 1);
	end
	sp_serial_port u_sp_serial_port (.clk_in(clk_in), .rst_in(rst_in),
		.address_in(address_in), .read_in(read_in), .write_in(write_in),
		.writedata_in(writedata_in), .readdata_out(readdata_out),
		.waitrequest_out(waitrequest_out), .t1_ovf_in(t1_ovf_in), .t2_ovf_in(t2_ovf_in),
		.rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe_out(rxd_oe_out), .txd_out(txd_out),
		.irq_out(irq_out));
	sp_remote_model u_sp_remote_model (.clk_in(clk_in), .txd_in(txd_out), .rxd_in(rxd_in),
		.line_out(model_line));
	// ------------------------------------------------------------
	// Report, compare and bus tasks
	// ------------------------------------------------------------
	task automatic tally_and_finish;
		$display("checks=%0d mismatches=%0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
			error_cnt++;
		end
	endtask
	task automatic ok_chk(input logic ok);
		if (!ok)
		begin
			error_cnt++;
			tally_and_finish;
		end
	endtask
	task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk_in);
		address_in <= a;
		write_in <= wr;
		read_in <= !wr;
		writedata_in <= {24'h0, d};
		do
		begin
			@(posedge clk_in);
			n++;
		end while (waitrequest_out !== 1'b0 && n < 50);
		q = readdata_out;
		write_in <= 1'b0;
		read_in <= 1'b0;
		ok_chk(waitrequest_out === 1'b0);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		logic [31:0] q;
		bus(1'b0, a, 8'h00, q);
		chk(q, {24'h0, e});
	endtask
	function automatic logic [10:0] frame(input int m, input logic [7:0] d, input logic b9);
		return (m == 1) ? {2'h3, d, 1'b0} : {1'b1, b9, d, 1'b0};
	endfunction
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		logic [10:0] v;
		logic [7:0] c, d;
		logic ok;
		int bt, br;
		logic [7:0] fc [3];
		logic [10:0] ff [3];
		fc = '{8'hf0, 8'h70, 8'h40};
		// Middle entry: 8-bit frame whose stop bit is low
		ff = '{frame(3, 8'h77, 1'b0), 11'h4ee, frame(1, 8'h77, 1'b1)};
		rst_in = 1'b1;
		read_in = 1'b0;
		write_in = 1'b0;
		address_in = 8'h00;
		writedata_in = 32'h0;
		ok = 1'b1;
		repeat (8) @(posedge clk_in);
		rst_in <= 1'b0;
		rd_chk(SP_CTRL_ADDR, 8'h00);
		rd_chk(SP_CFG_ADDR, 8'h00);
		rd_chk(8'ha4, 8'h00);
		$display("test reset done");
		for (int m = 1; m < 4; m++)
		begin
			c = {2'(m), 6'h18};
			wr(SP_CFG_ADDR, 8'h02);
			wr(SP_CTRL_ADDR, c);
			bt = (m == 2) ? 64 : 16 * T1P;
			br = (m == 2) ? 64 : 16 * T2P;
			fork
				begin
					wr(SP_BUF_ADDR, 8'ha5);
					u_sp_remote_model.recv((m == 1) ? 10 : 11, bt, v, ok);
				end
				u_sp_remote_model.send(frame(m, 8'h3c, 1'b1), 11, br);
			join
			ok_chk(ok);
			chk(v, frame(m, 8'ha5, 1'b1));
			rd_chk(SP_CTRL_ADDR, c | 8'h07);
			chk(irq_out, 1'b1);
			rd_chk(SP_BUF_ADDR, 8'h3c);
			wr(SP_CTRL_ADDR, c);
			$display("test mode %0d done", m);
		end
		wr(SP_CTRL_ADDR, 8'h50);
		u_sp_remote_model.send(frame(1, 8'h11, 1'b1), 11, 16 * T2P);
		u_sp_remote_model.send(frame(1, 8'h22, 1'b1), 11, 16 * T2P);
		rd_chk(SP_CTRL_ADDR, 8'h55);
		rd_chk(SP_BUF_ADDR, 8'h22);
		$display("test overrun done");
		for (int i = 0; i < 3; i++)
		begin
			wr(SP_CTRL_ADDR, fc[i]);
			u_sp_remote_model.send(ff[i], 11, 16 * T2P);
			rd_chk(SP_CTRL_ADDR, fc[i]);
		end
		$display("test filters done");
		wr(SP_CTRL_ADDR, 8'h00);
		fork
			wr(SP_BUF_ADDR, 8'h96);
			u_sp_remote_model.shift_cap(d, ok);
		join
		ok_chk(ok);
		chk(d, 8'h96);
		repeat (12) @(posedge clk_in);
		rd_chk(SP_CTRL_ADDR, 8'h02);
		fork
			u_sp_remote_model.shift_in(8'h4b, ok);
			wr(SP_CTRL_ADDR, 8'h10);
		join
		ok_chk(ok);
		repeat (12) @(posedge clk_in);
		rd_chk(SP_CTRL_ADDR, 8'h11);
		rd_chk(SP_BUF_ADDR, 8'h4b);
		$display("test shift mode done");
		tally_and_finish;
	end
endmodule
`default_nettype wire
